/* crt_refresh_address_mode_control.sv */
`timescale 1ns/10ps
`default_nettype none
module crt_refresh_address_mode_control
  import crt_refresh_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_N,
  input  wire logic [15:0]           IO_ADDR,
  input  wire logic                  IO_WR,
  input  wire logic                  IO_RD,
  input  wire logic [7:0]            IO_WDATA,
  input  wire logic [7:0]            CRT_INDEX,
  input  wire logic                  CHAR_CLK_TICK,
  input  wire logic                  HRETRACE_TICK,
  input  wire logic [15:0]           START_ADDRESS,
  input  wire logic [15:0]           ROW_OFFSET,
  input  wire logic                  FRAME_START,
  input  wire logic                  ROW_END,
  input  wire logic [1:0]            ROW_SCAN,
  input  wire logic                  COMPARE_BIT8,
  input  wire logic                  COMPARE_BIT9,
  input  wire logic [VERT_WIDTH-1:0] VERT_TOTAL,
  input  wire logic                  HRETRACE_RAW,
  input  wire logic                  VRETRACE_RAW,
  output logic [7:0]                 IO_RDATA,
  output logic [ADDR_WIDTH-1:0]      MEMORY_ADDRESS_OUT,
  output logic                       HRETRACE_OUT,
  output logic                       VRETRACE_OUT,
  output logic [VERT_WIDTH:0]        VERT_COUNT,
  output logic                       SPLIT_ACTIVE
);

  // All state of this level in one record; the rate divider keeps its own phase
  typedef struct packed {
    logic [7:0]            mode;
    logic [7:0]            compare;
    logic [7:0]            underline;
    addr_mode_type         amode;
    logic                  wrap;
    logic                  sel1;
    logic                  sel0;
    logic                  half;
    logic                  quarter;
    logic [15:0]           row_base;
    logic [15:0]           counter;
    logic [VERT_WIDTH:0]   vcount;
    logic                  vphase;
    logic                  split;
    logic [7:0]            rdata;
    logic [ADDR_WIDTH-1:0] addr_out;
    logic                  hr_out;
    logic                  vr_out;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic                  data_port_hit;
  logic                  counter_advance;
  logic [15:0]           mapped;
  logic [VERT_WIDTH-1:0] compare_target;
  logic                  vert_advance;

  // ************************************************************
  // Data port decode
  // ************************************************************
  // Both colour and mono data ports reach the same registers
  assign data_port_hit = (IO_ADDR == DATA_PORT_COLOR) || (IO_ADDR == DATA_PORT_MONO);

  // Ten-bit compare target assembled from three registers
  assign compare_target = {COMPARE_BIT9, COMPARE_BIT8, state_reg.compare};

  // Vertical counter advances on every retrace, or every other one
  assign vert_advance = HRETRACE_TICK && (!state_reg.mode[BIT_VERT_CLOCK_HALVE] || state_reg.vphase);

  // ************************************************************
  // Submodules
  // ************************************************************
  crt_rate_divider u_rate (
    .SYS_CLK      (SYS_CLK),
    .RST_N        (RST_N),
    .tick         (CHAR_CLK_TICK),
    .half_rate    (state_reg.half),
    .quarter_rate (state_reg.quarter),
    .advance      (counter_advance)
  );

  crt_addr_mux u_mux (
    .counter              (state_reg.counter),
    .row_scan             (ROW_SCAN),
    .mode                 (state_reg.amode),
    .address_wrap_select  (state_reg.wrap),
    .row_scan_bit1_select (state_reg.sel1),
    .row_scan_bit0_select (state_reg.sel0),
    .mapped               (mapped)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    // Register writes through the data port
    if (IO_WR && data_port_hit) begin
      if (CRT_INDEX == IDX_ADDRESSING_MODE) begin
        state_next.mode = IO_WDATA & WRITABLE_MODE_MASK;
      end else if (CRT_INDEX == IDX_LINE_COMPARE) begin
        state_next.compare = IO_WDATA;
      end else if (CRT_INDEX == IDX_UNDERLINE) begin
        state_next.underline = IO_WDATA;
      end
    end
    // Reads return the stored value; unused bit stays zero
    if (IO_RD && data_port_hit) begin
      if (CRT_INDEX == IDX_ADDRESSING_MODE) begin
        state_next.rdata = state_reg.mode;
      end else if (CRT_INDEX == IDX_LINE_COMPARE) begin
        state_next.rdata = state_reg.compare;
      end else if (CRT_INDEX == IDX_UNDERLINE) begin
        state_next.rdata = state_reg.underline;
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    // Mode copies move only on a character boundary so the
    // address never shows half an old and half a new mode
    if (CHAR_CLK_TICK) begin
      if (state_reg.underline[BIT_DOUBLEWORD]) begin
        state_next.amode = ADDR_DOUBLEWORD;
      end else if (!state_reg.mode[BIT_WORD_BYTE]) begin
        state_next.amode = ADDR_WORD;
      end else begin
        state_next.amode = ADDR_BYTE;
      end
      state_next.wrap    = state_reg.mode[BIT_ADDRESS_WRAP];
      state_next.sel1    = state_reg.mode[BIT_ROW_SCAN_BIT1_SEL];
      state_next.sel0    = state_reg.mode[BIT_ROW_SCAN_BIT0_SEL];
      state_next.half    = state_reg.mode[BIT_COUNT_HALF_RATE];
      state_next.quarter = state_reg.underline[BIT_COUNT_QUARTER];
    end
    // Address counter: reload per frame and row, step otherwise
    if (FRAME_START) begin
      state_next.row_base = START_ADDRESS;
      state_next.counter  = START_ADDRESS;
      state_next.split    = 1'b0;
    end else if (ROW_END) begin
      state_next.row_base = state_reg.row_base + ROW_OFFSET;
      state_next.counter  = state_reg.row_base + ROW_OFFSET;
    end else if (counter_advance) begin
      state_next.counter = state_reg.counter + 16'd1;
    end
    // Vertical counter clears only on frame start and never wraps at the total; 11 bits hold the doubled range
    if (HRETRACE_TICK) begin
      state_next.vphase = !state_reg.vphase;
    end
    if (FRAME_START) begin
      state_next.vcount = '0;
      state_next.vphase = 1'b0;
    end else if (vert_advance) begin
      state_next.vcount = state_reg.vcount + 11'd1;
      // Split point: lower screen restarts at zero, ignoring scroll
      if (state_reg.vcount[VERT_WIDTH-1:0] == compare_target) begin
        state_next.row_base = 16'h0000;
        state_next.counter  = 16'h0000;
        state_next.split    = 1'b1;
      end
    end
    state_next.addr_out = mapped[ADDR_WIDTH-1:0];
    // Retrace gate affects only these two outputs
    state_next.hr_out = state_reg.mode[BIT_RETRACE_ENABLE] && HRETRACE_RAW;
    state_next.vr_out = state_reg.mode[BIT_RETRACE_ENABLE] && VRETRACE_RAW;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg           <= '0;
      state_reg.mode      <= MODE_RESET_VALUE;
      state_reg.compare   <= COMPARE_RESET_VALUE;
      state_reg.underline <= UNDERLINE_RESET;
      state_reg.amode     <= ADDR_WORD;
    end else begin
      state_reg <= state_next;
    end
  end

  assign IO_RDATA           = state_reg.rdata;
  assign MEMORY_ADDRESS_OUT = state_reg.addr_out;
  assign HRETRACE_OUT       = state_reg.hr_out;
  assign VRETRACE_OUT       = state_reg.vr_out;
  assign VERT_COUNT         = state_reg.vcount;
  assign SPLIT_ACTIVE       = state_reg.split;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_RETRACE_GATED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !state_reg.mode[BIT_RETRACE_ENABLE] |=> !HRETRACE_OUT && !VRETRACE_OUT)
    else $error("retrace output active while disabled");

  AST_RETRACE_PASSES: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.mode[BIT_RETRACE_ENABLE] |=> HRETRACE_OUT == $past(HRETRACE_RAW))
    else $error("enabled retrace not passed through");

  AST_UNUSED_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !state_reg.mode[BIT_UNUSED])
    else $error("unused mode bit stored as one");

  AST_WRITE_STORES: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IO_WR && data_port_hit && CRT_INDEX == IDX_ADDRESSING_MODE
    |=> state_reg.mode == ($past(IO_WDATA) & WRITABLE_MODE_MASK))
    else $error("mode write lost");

  AST_DOUBLEWORD_WINS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CHAR_CLK_TICK && state_reg.underline[BIT_DOUBLEWORD] |=> state_reg.amode == ADDR_DOUBLEWORD)
    else $error("doubleword not selected");

  AST_WORD_OUT0: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.amode == ADDR_WORD |=> MEMORY_ADDRESS_OUT[0] ==
      ($past(state_reg.wrap) ? $past(state_reg.counter[15]) : $past(state_reg.counter[13])))
    else $error("word mode output 0 wrong");

  AST_BYTE_OUT0: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.amode == ADDR_BYTE |=> MEMORY_ADDRESS_OUT[0] == $past(state_reg.counter[0]))
    else $error("byte mode output 0 wrong");

  AST_DOUBLEWORD_LOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.amode == ADDR_DOUBLEWORD |=> MEMORY_ADDRESS_OUT[1:0] == $past(state_reg.counter[13:12]))
    else $error("doubleword low outputs wrong");

  AST_ROW_SCAN13: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !state_reg.sel0 |=> MEMORY_ADDRESS_OUT[13] == $past(ROW_SCAN[0]))
    else $error("output 13 not row scan bit 0");

  AST_ROW_SCAN14: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !state_reg.sel1 |=> MEMORY_ADDRESS_OUT[14] == $past(ROW_SCAN[1]))
    else $error("output 14 not row scan bit 1");

  AST_SPLIT_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !FRAME_START && vert_advance && state_reg.vcount[VERT_WIDTH-1:0] == compare_target
    |=> state_reg.counter == 16'h0000 && SPLIT_ACTIVE)
    else $error("split compare did not clear address");

  AST_VERT_HALF: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.mode[BIT_VERT_CLOCK_HALVE] && HRETRACE_TICK && !state_reg.vphase && !FRAME_START
    |=> $stable(VERT_COUNT))
    else $error("halved vertical clock advanced early");

  // ************************************************************
  // Register and retrace checks
  // ************************************************************
  // Reset is seen one edge late, once the disable has lifted
  AST_RESET_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> state_reg.mode == MODE_RESET_VALUE && state_reg.compare == COMPARE_RESET_VALUE
      && !HRETRACE_OUT && !VRETRACE_OUT)
    else $error("registers not cleared by reset");

  AST_VRETRACE_PASSES: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.mode[BIT_RETRACE_ENABLE] |=> VRETRACE_OUT == $past(VRETRACE_RAW))
    else $error("enabled vertical retrace not passed through");

  AST_COMPARE_STORES: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IO_WR && data_port_hit && CRT_INDEX == IDX_LINE_COMPARE |=> state_reg.compare == $past(IO_WDATA))
    else $error("line compare write lost");

  // ************************************************************
  // Mapping checks
  // ************************************************************
  // Shift checks need both row scan selects off the counter
  AST_WORD_SHIFT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.amode == ADDR_WORD && state_reg.sel0 && state_reg.sel1
    |=> MEMORY_ADDRESS_OUT[15:1] == $past(state_reg.counter[14:0]))
    else $error("word mode shift wrong");

  AST_DOUBLEWORD_SHIFT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.amode == ADDR_DOUBLEWORD && state_reg.sel0 && state_reg.sel1
    |=> MEMORY_ADDRESS_OUT[15:2] == $past(state_reg.counter[13:0]))
    else $error("doubleword shift wrong");

  AST_BYTE_PASS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.amode == ADDR_BYTE && state_reg.sel0 && state_reg.sel1
    |=> MEMORY_ADDRESS_OUT == $past(state_reg.counter))
    else $error("byte mode address wrong");

  AST_WORD_SELECT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CHAR_CLK_TICK && !state_reg.underline[BIT_DOUBLEWORD] && !state_reg.mode[BIT_WORD_BYTE]
    |=> state_reg.amode == ADDR_WORD)
    else $error("word mode not selected");

  AST_BYTE_SELECT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CHAR_CLK_TICK && !state_reg.underline[BIT_DOUBLEWORD] && state_reg.mode[BIT_WORD_BYTE]
    |=> state_reg.amode == ADDR_BYTE)
    else $error("byte mode not selected");

  AST_MODE_HELD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !CHAR_CLK_TICK |=> $stable(state_reg.amode) && $stable(state_reg.wrap))
    else $error("mode copy moved off a character boundary");

  // ************************************************************
  // Counter checks
  // ************************************************************
  AST_COUNT_FULL: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CHAR_CLK_TICK && !state_reg.half && !state_reg.quarter |=> counter_advance)
    else $error("full rate counter missed a tick");

  AST_ADVANCE_NEEDS_TICK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    counter_advance |-> $past(CHAR_CLK_TICK))
    else $error("counter advanced without a tick");

  AST_VERT_FULL: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !state_reg.mode[BIT_VERT_CLOCK_HALVE] && HRETRACE_TICK && !FRAME_START
    |=> VERT_COUNT == $past(VERT_COUNT) + 11'd1)
    else $error("vertical count missed a retrace");

  AST_VERT_HALF_STEP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    state_reg.mode[BIT_VERT_CLOCK_HALVE] && HRETRACE_TICK && state_reg.vphase && !FRAME_START
    |=> VERT_COUNT == $past(VERT_COUNT) + 11'd1)
    else $error("halved vertical count did not step");

  AST_SPLIT_HOLDS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    SPLIT_ACTIVE && !FRAME_START |=> SPLIT_ACTIVE)
    else $error("split flag dropped inside a frame");

endmodule // crt_refresh_address_mode_control
`default_nettype wire

/* crt_refresh_pkg.sv */
package crt_refresh_pkg;

  // ************************************************************
  // Register indexes and data port addresses
  // ************************************************************
  localparam logic [7:0]  IDX_ADDRESSING_MODE = 8'h17;
  localparam logic [7:0]  IDX_LINE_COMPARE    = 8'h18;
  localparam logic [7:0]  IDX_UNDERLINE       = 8'h14;
  localparam logic [15:0] DATA_PORT_COLOR     = 16'h03D5;
  localparam logic [15:0] DATA_PORT_MONO      = 16'h03B5;

  // ************************************************************
  // Field positions in the addressing mode control register
  // ************************************************************
  localparam int BIT_RETRACE_ENABLE    = 7;
  localparam int BIT_WORD_BYTE         = 6;
  localparam int BIT_ADDRESS_WRAP      = 5;
  localparam int BIT_UNUSED            = 4;
  localparam int BIT_COUNT_HALF_RATE   = 3;
  localparam int BIT_VERT_CLOCK_HALVE  = 2;
  localparam int BIT_ROW_SCAN_BIT1_SEL = 1;
  localparam int BIT_ROW_SCAN_BIT0_SEL = 0;

  // ************************************************************
  // Field positions in the underline location register
  // ************************************************************
  localparam int BIT_DOUBLEWORD        = 6;
  localparam int BIT_COUNT_QUARTER     = 5;

  // ************************************************************
  // Reset values and counter limits
  // ************************************************************
  localparam logic [7:0] MODE_RESET_VALUE    = 8'h00;
  localparam logic [7:0] COMPARE_RESET_VALUE = 8'h00;
  localparam logic [7:0] UNDERLINE_RESET     = 8'h00;
  localparam logic [7:0] WRITABLE_MODE_MASK  = 8'hEF;
  localparam int         VERT_WIDTH          = 10;
  localparam int         VERT_LINES_MAX      = 1024;

  // Address output selection
  typedef enum logic [1:0] {
    ADDR_BYTE       = 2'b00,
    ADDR_WORD       = 2'b01,
    ADDR_DOUBLEWORD = 2'b10
  } addr_mode_type;

endpackage

/* crt_rate_divider.sv */
`timescale 1ns/10ps
`default_nettype none
// Produces a one-cycle advance pulse every 1, 2 or 4 input ticks
module crt_rate_divider (
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic tick,
  input  wire logic half_rate,
  input  wire logic quarter_rate,
  output logic      advance
);

  typedef struct packed {
    logic [1:0] phase;
    logic       adv;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ************************************************************
  // Divider phase
  // ************************************************************
  // Quarter rate wins over half rate
  always_comb begin
    state_next     = state_reg;
    state_next.adv = 1'b0;
    if (tick) begin
      state_next.phase = state_reg.phase + 2'd1;
      if (quarter_rate) begin
        state_next.adv = (state_reg.phase == 2'd3);
      end else if (half_rate) begin
        state_next.adv = state_reg.phase[0];
      end else begin
        state_next.adv = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign advance = state_reg.adv;

endmodule // crt_rate_divider
`default_nettype wire

/* crt_addr_mux.sv */
`timescale 1ns/10ps
`default_nettype none
// Maps the address counter and row scan onto the refresh address
module crt_addr_mux
  import crt_refresh_pkg::*;
(
  input  wire logic [15:0]        counter,
  input  wire logic [1:0]         row_scan,
  input  wire crt_refresh_pkg::addr_mode_type mode,
  input  wire logic               address_wrap_select,
  input  wire logic               row_scan_bit1_select,
  input  wire logic               row_scan_bit0_select,
  output logic [15:0]             mapped
);

  logic [15:0] shifted;

  // ************************************************************
  // Mode shift then row scan substitution
  // ************************************************************
  always_comb begin
    case (mode)
      ADDR_DOUBLEWORD: shifted = {counter[13:0], counter[13], counter[12]};
      ADDR_WORD:       shifted = {counter[14:0],
                                  address_wrap_select ? counter[15] : counter[13]};
      default:         shifted = counter;
    endcase
    mapped     = shifted;
    mapped[14] = row_scan_bit1_select ? shifted[14] : row_scan[1];
    mapped[13] = row_scan_bit0_select ? shifted[13] : row_scan[0];
  end

endmodule // crt_addr_mux
`default_nettype wire

/* crt_display_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// Monitor stand-in
// ********
module crt_display_partner (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hretrace,
  input  wire logic        vretrace,
  output logic [15:0]      hsync_count,
  output logic [15:0]      vsync_count
);
  logic hretrace_reg;
  logic vretrace_reg;
  // Monitor counts retrace starts; a held level must not count twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hretrace_reg <= 1'b0;
      vretrace_reg <= 1'b0;
      hsync_count  <= 16'h0000;
      vsync_count  <= 16'h0000;
    end else begin
      hretrace_reg <= hretrace;
      vretrace_reg <= vretrace;
      if (hretrace && !hretrace_reg) hsync_count <= hsync_count + 16'h0001;
      if (vretrace && !vretrace_reg) vsync_count <= vsync_count + 16'h0001;
    end
  end
endmodule // crt_display_partner
`default_nettype wire

/* crt_refresh_address_mode_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module crt_refresh_address_mode_control_test;
  import crt_refresh_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [15:0]           io_addr = 16'h0000;
  logic                  io_wr = 1'b0;
  logic                  io_rd = 1'b0;
  logic [7:0]            io_wdata = 8'h00;
  logic [7:0]            crt_index = 8'h00;
  logic                  char_tick = 1'b0;
  logic                  hr_tick = 1'b0;
  logic                  frame_start = 1'b0;
  logic [15:0]           start_address = 16'h0000;
  logic [1:0]            row_scan = 2'b00;
  logic                  bit8 = 1'b0;
  logic                  bit9 = 1'b0;
  logic                  hr_raw = 1'b1;
  logic                  vr_raw = 1'b1;
  logic [7:0]            rdata;
  logic [15:0]           maddr;
  logic                  hr_out;
  logic                  vr_out;
  logic                  split;
  logic [VERT_WIDTH:0]   vcount;
  logic [15:0]           hsync_count;
  logic [15:0]           vsync_count;
  logic [7:0]            rd;
  logic [7:0]            mode;
  logic [7:0]            uline;
  logic [15:0]           seen;
  int                    errors = 0;
  int                    n_compared = 0;
  logic [7:0] corner_mode [7] = '{8'h00, 8'h20, 8'h43, 8'h63, 8'h03, 8'h03, 8'h43};
  logic [7:0] corner_ul   [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40};

  // Free running system clock
  always #5 sys_clk = ~sys_clk;

  crt_refresh_address_mode_control uut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .CRT_INDEX(crt_index), .CHAR_CLK_TICK(char_tick), .HRETRACE_TICK(hr_tick),
    .START_ADDRESS(start_address), .ROW_OFFSET(16'h0050), .FRAME_START(frame_start), .ROW_END(1'b0),
    .ROW_SCAN(row_scan), .COMPARE_BIT8(bit8), .COMPARE_BIT9(bit9), .VERT_TOTAL(10'h3FF),
    .HRETRACE_RAW(hr_raw), .VRETRACE_RAW(vr_raw), .IO_RDATA(rdata), .MEMORY_ADDRESS_OUT(maddr),
    .HRETRACE_OUT(hr_out), .VRETRACE_OUT(vr_out), .VERT_COUNT(vcount), .SPLIT_ACTIVE(split));

  crt_display_partner partner (
    .clk(sys_clk), .rst_n(rst_n), .hretrace(hr_out), .vretrace(vr_out),
    .hsync_count(hsync_count), .vsync_count(vsync_count));

  // ********
  // Shared tasks and expectations
  // ********
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic reg_write(input logic [15:0] port, input logic [7:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr   <= port;
    crt_index <= idx;
    io_wdata  <= d;
    io_wr     <= 1'b1;
    @(posedge sys_clk);
    io_wr     <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic reg_read(input logic [15:0] port, input logic [7:0] idx, output logic [7:0] d);
    @(posedge sys_clk);
    io_addr   <= port;
    crt_index <= idx;
    io_rd     <= 1'b1;
    @(posedge sys_clk);
    io_rd     <= 1'b0;
    @(posedge sys_clk);
    #1 d = rdata;
  endtask

  // One-cycle pulse: 0 character tick, 1 retrace tick, 2 frame start
  task automatic pulse(input int which);
    @(posedge sys_clk);
    if (which == 0) char_tick <= 1'b1;
    else if (which == 1) hr_tick <= 1'b1;
    else frame_start <= 1'b1;
    @(posedge sys_clk);
    char_tick   <= 1'b0;
    hr_tick     <= 1'b0;
    frame_start <= 1'b0;
    cycles(3);
  endtask

  // Mode only lands on a character tick, which also steps the counter, so reload after
  task automatic set_mode(input logic [7:0] m, input logic [7:0] u);
    reg_write(DATA_PORT_COLOR, IDX_ADDRESSING_MODE, m);
    reg_write(DATA_PORT_COLOR, IDX_UNDERLINE, u);
    pulse(0);
    pulse(2);
  endtask

  function automatic logic [15:0] exp_addr(input logic [15:0] c, input logic [7:0] m, input logic [7:0] u,
                                           input logic [1:0] rs);
    logic [15:0] a;
    if (u[BIT_DOUBLEWORD]) a = {c[13:0], c[13], c[12]};
    else if (!m[BIT_WORD_BYTE]) a = {c[14:0], m[BIT_ADDRESS_WRAP] ? c[15] : c[13]};
    else a = c;
    if (!m[BIT_ROW_SCAN_BIT1_SEL]) a[14] = rs[1];
    if (!m[BIT_ROW_SCAN_BIT0_SEL]) a[13] = rs[0];
    return a;
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(32'hC309C79E));
    cycles(10);
    rst_n <= 1'b1;
    cycles(2);
    reg_read(DATA_PORT_COLOR, IDX_ADDRESSING_MODE, rd);
    check_val("mode after reset", 16'h0000, {8'h00, rd});
    reg_read(DATA_PORT_COLOR, IDX_LINE_COMPARE, rd);
    check_val("compare after reset", 16'h0000, {8'h00, rd});
    check_val("retrace after reset", 16'h0000, {14'h0000, hr_out, vr_out});
    $display("test reset finished");
    reg_write(DATA_PORT_COLOR, IDX_ADDRESSING_MODE, 8'hFF);
    reg_write(16'h03C5, IDX_ADDRESSING_MODE, 8'h00);
    reg_write(DATA_PORT_COLOR, 8'h16, 8'h00);
    reg_read(DATA_PORT_MONO, IDX_ADDRESSING_MODE, rd);
    check_val("mode readback", {8'h00, WRITABLE_MODE_MASK}, {8'h00, rd});
    reg_read(DATA_PORT_COLOR, 8'h19, rd);
    check_val("unmapped read", 16'h0000, {8'h00, rd});
    $display("test registers finished");
    // Retrace gating: disabled outputs must stay low and the monitor must see nothing
    set_mode(8'hC3, 8'h00);
    check_val("retrace enabled", 16'h0003, {14'h0000, hr_out, vr_out});
    set_mode(8'h43, 8'h00);
    seen = hsync_count;
    repeat (3) begin
      @(posedge sys_clk);
      hr_raw <= ~hr_raw;
      cycles(2);
    end
    check_val("retrace disabled", 16'h0000, {14'h0000, hr_out, vr_out});
    check_val("monitor syncs", seen, hsync_count);
    check_val("monitor vsyncs", 16'h0001, vsync_count);
    reg_read(DATA_PORT_COLOR, IDX_ADDRESSING_MODE, rd);
    check_val("mode kept", 16'h0043, {8'h00, rd});
    check_val("address kept", start_address, maddr);
    $display("test retrace finished");
    // Mapping: corners first, then random modes, addresses and row scans
    for (int i = 0; i < 20; i++) begin
      mode  = (i < 7) ? corner_mode[i] : 8'($urandom) & WRITABLE_MODE_MASK;
      uline = (i < 7) ? corner_ul[i] : 8'($urandom) & 8'h40;
      @(posedge sys_clk);
      start_address <= 16'($urandom);
      row_scan      <= 2'($urandom);
      set_mode(mode, uline);
      check_val("refresh address", exp_addr(start_address, mode, uline, row_scan), maddr);
    end
    $display("test mapping finished");
    // Counter rates: eight ticks divide evenly whatever the divider phase
    for (int r = 0; r < 3; r++) begin
      @(posedge sys_clk);
      start_address <= 16'h0100;
      set_mode((r == 1) ? 8'h4B : 8'h43, (r == 2) ? 8'h20 : 8'h00);
      repeat (8) pulse(0);
      check_val("address steps", (r == 0) ? 16'h0108 : (r == 1) ? 16'h0104 : 16'h0102, maddr);
    end
    $display("test rates finished");
    // Vertical clock and split compare, target parked at the top for the rate check
    reg_write(DATA_PORT_COLOR, IDX_LINE_COMPARE, 8'hFF);
    @(posedge sys_clk);
    bit8 <= 1'b1;
    bit9 <= 1'b1;
    for (int h = 0; h < 2; h++) begin
      set_mode(h ? 8'h47 : 8'h43, 8'h00);
      repeat (6) pulse(1);
      check_val("vertical count", h ? 16'h0003 : 16'h0006, {5'h00, vcount});
    end
    set_mode(8'h43, 8'h00);
    repeat (1023) pulse(1);
    check_val("top line no split", {4'h0, 11'h3FF, 1'b0}, {4'h0, vcount, split});
    pulse(1);
    check_val("top line split", {4'h0, 11'h400, 1'b1}, {4'h0, vcount, split});
    reg_write(DATA_PORT_COLOR, IDX_LINE_COMPARE, 8'h03);
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      bit8          <= (k == 1);
      bit9          <= (k == 2);
      start_address <= 16'h1234;
      set_mode(8'h43, 8'h00);
      repeat (5) pulse(1);
      check_val("split flag", {15'h0000, k == 0}, {15'h0000, split});
      check_val("split address", (k == 0) ? 16'h0000 : 16'h1234, maddr);
    end
    $display("test vertical finished");
    complete_run();
  end

  // Watchdog: the run needs about 5900 cycles, so allow about eight and a half times that
  initial begin
    #500000;
    errors++;
    complete_run();
  end
endmodule // crt_refresh_address_mode_control_test
`default_nettype wire
